// >>> src/pbs_map.svh
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH
// What this block does
// - chip select three, active low, sampled at the edge with the others
// - chip select one is active low, chip select two active high, both sampled
// - output enable low drives data pins; high floats them as write inputs
// - first read cycle after deselect keeps pins floating regardless of enable
// - burst step low during a burst moves to the next burst address
// - processor strobe captures address and loads low two bits into counter
// - controller strobe captures address and loads low two bits into counter
// - both strobes low with chip select one low: only the processor strobe is honoured
// - processor strobe ignored while chip select one is high
// - sleep request high gives low-power state keeping data; low is normal
// - write data registered at the edge; read data from previous edge address
// - order strap low selects linear, high selects interleaved; kept static
// - synchronous inputs taken at the rising edge; read data leaves registers
// - two-bit wrapping counter holds burst start and makes following addresses
// - linear adds count modulo four; interleaved xors start with the count
// - byte enable with lane selects qualifies byte writes; global write all
// - read starts on a strobe with all selects active; controller strobe also needs no write asserted
// - read data appears after the following edge when output enable is low
// - consecutive single reads run with no idle cycles
// - after a deselect, outputs float only after the next edge
`define PBS_DATA_W      32
`define PBS_ADDR_W      17
`define PBS_LANE_W      8
`define PBS_FIFO_DEPTH  16
`define PBS_BURST_W     2
`define PBS_BURST_LSB   0
`define PBS_SLEEP_CYC   2
`define PBS_CLK_NS      4
`define PBS_ORDER_RST   1'b1
`define PBS_BUF_MARGIN  2
`endif

// >>> src/pbs_pkg.sv
`include "pbs_map.svh"
package pbs_pkg;
  // what the current access is doing
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } pbs_cyc_t;
  // sleep entry and exit sequence
  typedef enum logic [1:0] {
    SLP_AWAKE,
    SLP_ENTER,
    SLP_ASLEEP,
    SLP_EXIT
  } pbs_slp_t;
endpackage

// >>> src/pbs_stream_if.sv
`timescale 1ns/100ps
interface pbs_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  // producer side
  modport src (output valid, output data, input ready);
  // consumer side
  modport snk (input valid, input data, output ready);
endinterface

// >>> src/pbs_fifo.sv
`timescale 1ns/100ps
`include "pbs_map.svh"
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `PBS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic     ref_clk,
  input wire logic     srst,
  // filling and draining sides
  pbs_stream_if.snk    push,
  pbs_stream_if.src    pop
);
  localparam int PW = $clog2(DEPTH);

  // pointer arithmetic needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pbs_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr_r;
  logic [PW:0]      rd_ptr_r;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty
  assign full  = (wr_ptr_r[PW] != rd_ptr_r[PW]) &&
                 (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign push.ready = ~full;
  assign pop.valid  = ~empty;
  assign pop.data   = store[rd_ptr_r[PW-1:0]];

  // storage has no reset, pointers guard it
  always_ff @(posedge ref_clk) begin
    if (push.valid && !full) begin
      store[wr_ptr_r[PW-1:0]] <= push.data;
    end
  end

  // fill pointer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
    end else if (push.valid && !full) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  // drain pointer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_ptr_r <= '0;
    end else if (pop.ready && !empty) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// >>> src/pbs_burst_ctr.sv
`timescale 1ns/100ps
`include "pbs_map.svh"
module pbs_burst_ctr #(
  parameter int CNT_W = `PBS_BURST_W
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              srst,
  // control
  input wire logic              load,
  input wire logic [CNT_W-1:0]  load_val,
  input wire logic              step,
  input wire logic              linear,
  // current low address bits
  output logic [CNT_W-1:0]      cur
);
  if (CNT_W < 1) begin : g_bad_w
    $error("pbs_burst_ctr needs at least one bit");
  end

  logic [CNT_W-1:0] base_r;
  logic [CNT_W-1:0] cnt_r;

  // start address kept, offset wraps on its own width
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      base_r <= '0;
      cnt_r  <= '0;
    end else if (load) begin
      base_r <= load_val;
      cnt_r  <= '0;
    end else if (step) begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end

  // linear adds, interleaved xors the same offset
  assign cur = linear ? base_r + cnt_r : base_r ^ cnt_r;
endmodule

// >>> src/pbs_sram_top.sv
`timescale 1ns/100ps
`include "pbs_map.svh"
module pbs_sram_top #(
  parameter int ADDR_W     = `PBS_ADDR_W,
  parameter int DATA_W     = `PBS_DATA_W,
  parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH,
  parameter int SLEEP_CYC  = `PBS_SLEEP_CYC
) (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    srst,
  // address and selects
  input wire logic [ADDR_W-1:0]       addr,
  input wire logic                    chip_select_one_n,
  input wire logic                    chip_select_two,
  input wire logic                    chip_select_three_n,
  // strobes and burst control
  input wire logic                    proc_addr_strobe_n,
  input wire logic                    ctrl_addr_strobe_n,
  input wire logic                    burst_step_n,
  // write control
  input wire logic                    global_write_n,
  input wire logic                    byte_write_en_n,
  input wire logic [DATA_W/8-1:0]     byte_lane_sel_n,
  // asynchronous controls and strap
  input wire logic                    out_en_n,
  input wire logic                    sleep_req,
  input wire logic                    burst_order,
  // data bus, split into its three signals
  input wire logic [DATA_W-1:0]       dq_in,
  output logic [DATA_W-1:0]           dq_out,
  output logic                        dq_oe,
  // status
  output logic                        sleep_active,
  output logic                        buf_ready,
  output logic                        wr_idle
);
  localparam int LANES = DATA_W / `PBS_LANE_W;
  localparam int WW    = LANES + ADDR_W + DATA_W;
  localparam int WORDS = 1 << ADDR_W;
  localparam int SCW   = $clog2(SLEEP_CYC + 1);
  localparam int OCW   = $clog2(FIFO_DEPTH + 1);
  localparam int BW    = `PBS_BURST_W;

  // refuse shapes the lane, burst, sleep and queue logic cannot serve
  if (DATA_W % `PBS_LANE_W != 0 || LANES < 1) begin : g_bad_data
    $error("pbs_sram_top data width must be whole bytes");
  end
  if (ADDR_W <= BW) begin : g_bad_addr
    $error("pbs_sram_top address must be wider than the burst counter");
  end
  if (SLEEP_CYC < 1) begin : g_bad_sleep
    $error("pbs_sram_top sleep sequence needs at least one cycle");
  end
  if (FIFO_DEPTH <= `PBS_BUF_MARGIN) begin : g_bad_fifo
    $error("pbs_sram_top write queue too shallow for its margin");
  end

  // global write wins, else byte enable gates the lane selects
  function automatic logic [LANES-1:0] lane_mask(
    input logic             gw_n,
    input logic             bwe_n,
    input logic [LANES-1:0] sel_n
  );
    logic [LANES-1:0] m;
    m = '0;
    if (!gw_n) begin
      m = '1;
    end else if (!bwe_n) begin
      m = ~sel_n;
    end
    return m;
  endfunction

  // all three selects active together
  function automatic logic selected(
    input logic ce1_n,
    input logic ce2,
    input logic ce3_n
  );
    return ~ce1_n & ce2 & ~ce3_n;
  endfunction

  // ---------------------------------------------------------------
  // asynchronous inputs: sleep and strap pass two flip-flops
  logic slp_s1_r;
  logic slp_s2_r;
  logic ord_s1_r;
  logic ord_s2_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      slp_s1_r <= 1'b0;
      slp_s2_r <= 1'b0;
      ord_s1_r <= `PBS_ORDER_RST;
      ord_s2_r <= `PBS_ORDER_RST;
    end else begin
      slp_s1_r <= sleep_req;
      slp_s2_r <= slp_s1_r;
      ord_s1_r <= burst_order;
      ord_s2_r <= ord_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // sleep sequence: entry and exit each take SLEEP_CYC cycles
  pbs_pkg::pbs_slp_t slp_r;
  logic [SCW-1:0]    slp_cnt_r;
  logic              asleep;
  logic              sleep_active_r;
  logic              slp_last;

  assign slp_last = (slp_cnt_r == SCW'(SLEEP_CYC - 1));
  // accesses are refused while the sequence is anywhere but awake
  assign asleep   = (slp_r != pbs_pkg::SLP_AWAKE);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      slp_r          <= pbs_pkg::SLP_AWAKE;
      slp_cnt_r      <= '0;
      sleep_active_r <= 1'b0;
    end else begin
      case (slp_r)
        pbs_pkg::SLP_AWAKE: begin
          slp_cnt_r <= '0;
          if (slp_s2_r) begin
            slp_r <= pbs_pkg::SLP_ENTER;
          end
        end
        pbs_pkg::SLP_ENTER: begin
          slp_cnt_r <= slp_cnt_r + 1'b1;
          if (slp_last) begin
            slp_r          <= pbs_pkg::SLP_ASLEEP;
            slp_cnt_r      <= '0;
            sleep_active_r <= 1'b1;
          end
        end
        pbs_pkg::SLP_ASLEEP: begin
          if (!slp_s2_r) begin
            slp_r          <= pbs_pkg::SLP_EXIT;
            sleep_active_r <= 1'b0;
          end
        end
        pbs_pkg::SLP_EXIT: begin
          slp_cnt_r <= slp_cnt_r + 1'b1;
          if (slp_last) begin
            slp_r     <= pbs_pkg::SLP_AWAKE;
            slp_cnt_r <= '0;
          end
        end
        default: begin
          slp_r <= pbs_pkg::SLP_AWAKE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // access decode, all taken at the rising edge
  pbs_pkg::pbs_cyc_t cyc_r;
  logic              proc_ok;
  logic              ctrl_ok;
  logic              strobe;
  logic              sel_now;
  logic [LANES-1:0]  wr_mask;
  logic              wr_req;
  logic              start_rd;
  logic              start_wr;
  logic              desel;
  logic              cont;
  logic              cont_wr;
  logic              cont_rd;
  logic              write_now;
  logic              step;
  logic              buf_ready_r;

  // processor strobe counts only with chip select one low
  assign proc_ok  = ~proc_addr_strobe_n & ~chip_select_one_n;
  // controller strobe yields to an honoured processor strobe
  assign ctrl_ok  = ~ctrl_addr_strobe_n & ~proc_ok;
  assign strobe   = (proc_ok | ctrl_ok) & ~asleep;
  assign sel_now  = selected(chip_select_one_n, chip_select_two,
                             chip_select_three_n);
  assign wr_mask  = lane_mask(global_write_n, byte_write_en_n,
                              byte_lane_sel_n);
  // writes are refused while the queue has no room
  assign wr_req   = (|wr_mask) & buf_ready_r;
  // processor strobe ignores write inputs on its first cycle
  assign start_rd = strobe & sel_now & (proc_ok | ~(|wr_mask));
  assign start_wr = strobe & sel_now & ctrl_ok & wr_req;
  assign desel    = strobe & ~sel_now;
  assign cont     = ~strobe & ~asleep & (cyc_r != pbs_pkg::CYC_IDLE);
  assign cont_wr  = cont & wr_req;
  // a refused write is never turned into a read
  assign cont_rd  = cont & ~(|wr_mask);
  assign write_now = start_wr | cont_wr;
  // advance is only looked at when no strobe starts an access
  assign step     = cont & ~burst_step_n;

  // access state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_r <= pbs_pkg::CYC_IDLE;
    end else if (asleep || desel) begin
      cyc_r <= pbs_pkg::CYC_IDLE;
    end else if (start_wr || cont_wr) begin
      cyc_r <= pbs_pkg::CYC_WRITE;
    end else if (start_rd || cont_rd) begin
      cyc_r <= pbs_pkg::CYC_READ;
    end
  end

  // ---------------------------------------------------------------
  // address register and burst counter
  logic [ADDR_W-1:BW] addr_hi_r;
  logic [BW-1:0]      burst_lo;
  logic [ADDR_W-1:0]  cur_addr;

  // upper bits only move on a strobe, never on a step
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_hi_r <= '0;
    end else if (start_rd || start_wr) begin
      addr_hi_r <= addr[ADDR_W-1:BW];
    end
  end

  pbs_burst_ctr #(
    .CNT_W    (BW)
  ) u_burst (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .load     (start_rd | start_wr),
    .load_val (addr[`PBS_BURST_LSB +: BW]),
    .step     (step),
    .linear   (~ord_s2_r),
    .cur      (burst_lo)
  );

  assign cur_addr = {addr_hi_r, burst_lo};

  // ---------------------------------------------------------------
  // write capture: input data register plus the queue in front of the array
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [LANES-1:0]  wr_mask_r;
  logic [DATA_W-1:0] din_r;
  logic [OCW-1:0]    occ_r;
  logic [OCW-1:0]    occ_nxt;
  logic              push_go;
  logic              pop_go;
  logic              rd_valid_r;
  logic              wr_idle_r;

  pbs_stream_if #(.W(WW)) wr_push ();
  pbs_stream_if #(.W(WW)) wr_pop ();

  // controller strobe writes the presented address, later cycles the burst
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      wr_mask_r <= '0;
      din_r     <= '0;
    end else begin
      wr_pend_r <= write_now;
      din_r     <= dq_in;
      wr_mask_r <= wr_mask;
      wr_addr_r <= start_wr ? addr : cur_addr;
    end
  end

  assign wr_push.valid = wr_pend_r;
  assign wr_push.data  = {wr_mask_r, wr_addr_r, din_r};
  // array port goes to reads first; queue stalls meanwhile and in sleep
  assign wr_pop.ready  = ~asleep & ~rd_valid_r;
  assign push_go       = wr_push.valid & wr_push.ready;
  assign pop_go        = wr_pop.valid & wr_pop.ready;

  pbs_fifo #(
    .WIDTH    (WW),
    .DEPTH    (FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .push     (wr_push.snk),
    .pop      (wr_pop.src)
  );

  // occupancy with a margin, since one write may still be in flight
  always_comb begin
    occ_nxt = occ_r;
    if (push_go && !pop_go) begin
      occ_nxt = occ_r + 1'b1;
    end else if (pop_go && !push_go) begin
      occ_nxt = occ_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      occ_r       <= '0;
      buf_ready_r <= 1'b0;
      wr_idle_r   <= 1'b1;
    end else begin
      occ_r       <= occ_nxt;
      buf_ready_r <= occ_nxt < OCW'(FIFO_DEPTH - `PBS_BUF_MARGIN);
      wr_idle_r   <= (occ_nxt == '0) & ~write_now &
                     ~(wr_pend_r & ~push_go);
    end
  end

  // ---------------------------------------------------------------
  // read pipeline: address at one edge, data register at the next
  logic              drive_r;
  logic [DATA_W-1:0] dout_w;
  logic [ADDR_W-1:0] pop_addr;
  logic [LANES-1:0]  pop_mask;
  logic [DATA_W-1:0] pop_data;

  assign {pop_mask, pop_addr, pop_data} = wr_pop.data;

  // marks that the address register now names a word to read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= start_rd | cont_rd;
    end
  end

  // one array per byte lane keeps lane writes independent
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [`PBS_LANE_W-1:0] lane_mem [WORDS];
    logic [`PBS_LANE_W-1:0] lane_q_r;

    always_ff @(posedge ref_clk) begin
      if (pop_go && pop_mask[i]) begin
        lane_mem[pop_addr] <= pop_data[i*`PBS_LANE_W +: `PBS_LANE_W];
      end
    end

    // output register, loaded from the address of the previous edge
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        lane_q_r <= '0;
      end else if (rd_valid_r) begin
        lane_q_r <= lane_mem[cur_addr];
      end
    end

    assign dout_w[i*`PBS_LANE_W +: `PBS_LANE_W] = lane_q_r;
  end

  // pipelined enable: set one edge after the read, so a deselect
  // floats the pins only after the following edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      drive_r <= 1'b0;
    end else begin
      // a write seen at this edge floats the pins at once for safety
      drive_r <= rd_valid_r & ~write_now & ~asleep;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers; output enable acts without a clock
  assign dq_out       = dout_w;
  assign dq_oe        = drive_r & ~out_en_n;
  assign sleep_active = sleep_active_r;
  assign buf_ready    = buf_ready_r;
  assign wr_idle      = wr_idle_r;
endmodule

// >>> verif/pbs_sram_sva.sv
`timescale 1ns/100ps
module pbs_sram_sva #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                srst,
  // bus controls
  input wire logic [ADDR_W-1:0]   addr,
  input wire logic                chip_select_one_n,
  input wire logic                chip_select_two,
  input wire logic                chip_select_three_n,
  input wire logic                proc_addr_strobe_n,
  input wire logic                ctrl_addr_strobe_n,
  input wire logic                burst_step_n,
  input wire logic                global_write_n,
  input wire logic                byte_write_en_n,
  input wire logic [DATA_W/8-1:0] byte_lane_sel_n,
  input wire logic                out_en_n,
  input wire logic                sleep_req,
  input wire logic                burst_order,
  // data and status
  input wire logic [DATA_W-1:0]   dq_in,
  input wire logic [DATA_W-1:0]   dq_out,
  input wire logic                dq_oe,
  input wire logic                sleep_active,
  input wire logic                buf_ready,
  input wire logic                wr_idle
);
  logic sel, awake, rd_go, desel, nowr, wr_go;
  // cycle kinds as the device should decode them at the edge
  assign sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
  assign awake = !sleep_req && !sleep_active;
  assign rd_go = awake && sel && (!proc_addr_strobe_n
                 || (!ctrl_addr_strobe_n && global_write_n && byte_write_en_n));
  assign desel = awake && !sel && (!ctrl_addr_strobe_n
                 || (!proc_addr_strobe_n && !chip_select_one_n));
  assign nowr = proc_addr_strobe_n && ctrl_addr_strobe_n && global_write_n
                && byte_write_en_n;
  assign wr_go = awake && sel && buf_ready && !ctrl_addr_strobe_n
                 && proc_addr_strobe_n && (!global_write_n
                 || (!byte_write_en_n && !(&byte_lane_sel_n)));
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_oe_off;
    out_en_n |-> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data pins driven while output enable is high");
  property p_mask;
    desel ##1 rd_go ##1 nowr |-> !dq_oe ##1 (out_en_n || dq_oe);
  endproperty
  a_mask: assert property (p_mask)
    else $error("first read cycle after deselect not masked or late");
  property p_dcd_hold;
    !desel ##1 desel && dq_oe ##1 !out_en_n |-> dq_oe;
  endproperty
  a_dcd_hold: assert property (p_dcd_hold)
    else $error("outputs released too early after deselect");
  property p_dcd_off;
    desel |-> ##2 !dq_oe;
  endproperty
  a_dcd_off: assert property (p_dcd_off)
    else $error("outputs still driven two edges after deselect");
  property p_wr_float;
    wr_go |=> !dq_oe;
  endproperty
  a_wr_float: assert property (p_wr_float)
    else $error("outputs driven during a write cycle");
  property p_prio;
    (awake && sel && !proc_addr_strobe_n && !ctrl_addr_strobe_n
     && !global_write_n) ##1 nowr ##1 !out_en_n |-> dq_oe;
  endproperty
  a_prio: assert property (p_prio)
    else $error("controller strobe acted on beside processor strobe");
  property p_sleep_on;
    sleep_req [*8] |-> sleep_active && !dq_oe;
  endproperty
  a_sleep_on: assert property (p_sleep_on)
    else $error("sleep not entered in time");
  property p_sleep_off;
    !sleep_req [*8] |-> !sleep_active;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("sleep not left in time");
endmodule

// >>> verif/pbs_host_model.sv
`timescale 1ns/100ps
module pbs_host_model #(
  parameter int W = 32
) (
  // clock
  input wire logic         ref_clk,
  // device side of the data pins
  input wire logic [W-1:0] dq_out,
  input wire logic         dq_oe,
  // host write driver
  input wire logic         host_drv,
  input wire logic [W-1:0] host_data,
  // resolved wire and contention flag
  output logic [W-1:0]     dq_wire,
  output logic             clash
);
  logic [W-1:0] last_r;
  // remember the wire so a floating bus never repeats a stale word
  always @(posedge ref_clk) begin
    last_r <= dq_wire;
  end
  // no pull on these lines: released bus shows the inverse
  always_comb begin
    clash = dq_oe && host_drv;
    if (dq_oe) begin
      dq_wire = dq_out;
    end else if (host_drv) begin
      dq_wire = host_data;
    end else begin
      dq_wire = ~last_r;
    end
  end
endmodule

// >>> verif/tb_pbs_sram_top.sv
`timescale 1ns/100ps
`include "pbs_map.svh"
module tb_pbs_sram_top;
  localparam logic [16:0] BASE = 17'h01230;
  localparam logic [5:0]  NW   = 6'h3f;
  localparam logic [5:0]  GW   = 6'h1f;
  logic [`PBS_ADDR_W-1:0] addr;
  logic [`PBS_DATA_W-1:0] dq_in, dq_out, wd, host_data;
  logic [`PBS_DATA_W-1:0] mem_m [4];
  logic [3:0]             byte_lane_sel_n;
  logic                   ref_clk, srst, proc_addr_strobe_n, burst_step_n;
  logic                   ctrl_addr_strobe_n, global_write_n, byte_write_en_n;
  logic                   chip_select_one_n, chip_select_two, dq_oe, clash;
  logic                   chip_select_three_n, out_en_n, sleep_req, hd;
  logic                   burst_order, sleep_active, buf_ready, wr_idle;
  logic                   host_drv, oe_q, slp_q;
  int                     err_total, cmp_count;
  pbs_sram_top pbs_sram_top_inst (
    .ref_clk(ref_clk), .srst(srst), .addr(addr),
    .chip_select_one_n(chip_select_one_n), .chip_select_two(chip_select_two),
    .chip_select_three_n(chip_select_three_n),
    .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
    .global_write_n(global_write_n), .byte_write_en_n(byte_write_en_n),
    .byte_lane_sel_n(byte_lane_sel_n), .out_en_n(out_en_n),
    .sleep_req(sleep_req), .burst_order(burst_order), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .sleep_active(sleep_active),
    .buf_ready(buf_ready), .wr_idle(wr_idle));
  pbs_host_model pbs_host_model_inst (
    .ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe), .host_drv(host_drv),
    .host_data(host_data), .dq_wire(dq_in), .clash(clash));
  // free-running clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task results;
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle: controls change at the edge, outputs read 1 ns later
  task drv(input logic ps, input logic cs, input logic [2:0] sl,
           input logic st, input logic [5:0] w, input logic [16:0] a);
    @(posedge ref_clk);
    proc_addr_strobe_n <= ps;
    ctrl_addr_strobe_n <= cs;
    {chip_select_one_n, chip_select_two, chip_select_three_n} <= sl;
    burst_step_n <= st;
    {global_write_n, byte_write_en_n, byte_lane_sel_n} <= w;
    addr <= a;
    out_en_n <= oe_q;
    sleep_req <= slp_q;
    host_drv <= hd;
    host_data <= wd;
    #1;
  endtask
  // deselect until the write queue is empty; the array lags the queue
  task settle;
    int i;
    i = 0;
    repeat (2) drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
    while (wr_idle !== 1'b1 && i < 64) begin
      drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
      i++;
    end
    if (i == 64) chk(1'b0, 1'b1);
    repeat (2) drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
  endtask
  // controller strobe write; output enable is high when data goes on
  task wr(input logic [16:0] a, input logic [31:0] d, input logic [5:0] w);
    int i;
    for (i = 0; i < 32 && buf_ready !== 1'b1; i++) begin
      drv(1'b1, 1'b1, 3'b110, 1'b1, NW, a);
    end
    oe_q = 1'b1;
    hd = 1'b1;
    wd = d;
    drv(1'b1, 1'b0, 3'b010, 1'b1, w, a);
    hd = 1'b0;
    chk(clash, 1'b0);
    drv(1'b1, 1'b0, 3'b110, 1'b1, NW, a);
  endtask
  // read start, three steps, then a deselect of the kind given
  task burst(input logic [1:0] s, input logic lin, input logic [2:0] ds,
             input logic ps);
    int n;
    oe_q = 1'b0;
    drv(!ps, ps, 3'b010, 1'b1, NW, BASE | s);
    drv(1'b1, 1'b1, 3'b010, 1'b0, NW, BASE);
    chk(dq_oe, 1'b0);
    for (n = 0; n < 4; n++) begin
      drv(1'b1, n != 2, n == 2 ? ds : 3'b010, n > 1, NW, BASE);
      chk(dq_out, mem_m[lin ? 2'(s + n) : s ^ 2'(n)]);
      chk(dq_oe, 1'b1);
    end
    drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
    chk(dq_oe, 1'b0);
  endtask
  // strap first, then reset, then load the four burst words
  task start(input logic m);
    int i;
    @(posedge ref_clk);
    burst_order <= m;
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    drv(1'b1, 1'b1, 3'b110, 1'b1, NW, BASE);
    chk(dq_oe, 1'b0);
    chk(sleep_active, 1'b0);
    chk(wr_idle, 1'b1);
    chk(buf_ready, 1'b1);
    for (i = 0; i < 4; i++) begin
      mem_m[i] = 32'h5a000000 + 32'(i) * 32'h01010101 + 32'(m);
      wr(BASE | 17'(i), mem_m[i], GW);
    end
    settle();
  endtask
  // cut a hang short well past the expected run length
  initial begin
    #20000;
    chk(1'b0, 1'b1);
    results();
  end
  initial begin
    {srst, hd, slp_q, sleep_req, host_drv} = 5'h0;
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
    {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h6;
    {global_write_n, byte_write_en_n, byte_lane_sel_n} = NW;
    {out_en_n, oe_q, burst_order} = 3'h7;
    {addr, wd, host_data, err_total, cmp_count} = '0;
    start(1'b1);
    burst(2'd1, 1'b0, 3'b110, 1'b1);
    // both strobes with write inputs: stays a read of word two
    drv(1'b0, 1'b0, 3'b010, 1'b1, GW, BASE | 17'h2);
    drv(1'b1, 1'b1, 3'b010, 1'b1, NW, BASE);
    drv(1'b0, 1'b1, 3'b110, 1'b1, NW, BASE);
    chk(dq_out, mem_m[2]);
    drv(1'b1, 1'b1, 3'b010, 1'b1, NW, BASE);
    drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
    chk(dq_oe, 1'b1);
    chk(dq_out, mem_m[2]);
    settle();
    // processor strobe start, write inputs and data on the next edge
    oe_q = 1'b1;
    drv(1'b0, 1'b1, 3'b010, 1'b1, NW, BASE | 17'h1);
    wd = 32'h3c5a96e1;
    mem_m[1] = wd;
    hd = 1'b1;
    drv(1'b1, 1'b1, 3'b010, 1'b1, GW, BASE);
    hd = 1'b0;
    chk(clash, 1'b0);
    wr(BASE, 32'h11223344, 6'h2a);
    mem_m[0] = {mem_m[0][31:24], 8'h22, mem_m[0][15:8], 8'h44};
    settle();
    burst(2'd3, 1'b0, 3'b000, 1'b0);
    start(1'b0);
    burst(2'd3, 1'b1, 3'b011, 1'b1);
    // sleep keeps the array; the bus is idle meanwhile
    slp_q = 1'b1;
    repeat (10) drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
    chk(sleep_active, 1'b1);
    chk(dq_oe, 1'b0);
    slp_q = 1'b0;
    repeat (10) drv(1'b1, 1'b0, 3'b110, 1'b1, NW, BASE);
    chk(sleep_active, 1'b0);
    burst(2'd1, 1'b1, 3'b000, 1'b0);
    results();
  end
endmodule
bind pbs_sram_top pbs_sram_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  pbs_sram_sva_inst (.*);
